// File: hdl/ttc_edge.sv
// Once-per-machine-cycle falling-edge sampler for the count and trigger pins
`timescale 1ns/1ps
`default_nettype none
module ttc_edge #(
  parameter int N = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  ttc_tick_if.dst           tk,
  input  wire logic [N-1:0] pins,
  output var  logic [N-1:0] fall
);
  typedef struct packed {
    logic [N-1:0] smp;
    logic [N-1:0] fall;
  } ttc_edge_t;

  ttc_edge_t st;
  ttc_edge_t next_st;

  if (N < 1) begin : g_chk
    $error("ttc_edge needs at least one pin");
  end

  always_comb begin
    next_st      = st;
    next_st.fall = '0;
    for (int i = 0; i < N; i++) begin
      if (tk.mc) begin
        // High sample then low sample one machine cycle later
        next_st.fall[i] = st.smp[i] & ~pins[i];
        next_st.smp[i]  = pins[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fall = st.fall;
endmodule
`default_nettype wire

// File: hdl/ttc_pkg.sv
// Constants shared by the three-timer counter unit
package ttc_pkg;

  // ==========================================================
  // Clock and prescaling
  localparam int          CLK_MHZ       = 250;
  localparam int          MC_CLKS       = 4;
  localparam int          STD_DIV_MC    = 3;
  localparam int unsigned MC_CNT_W      = 2;
  localparam int unsigned STD_CNT_W     = 2;

  // ==========================================================
  // Timer mode register field positions
  localparam int          TMR0_MODE_LSB = 0;
  localparam int          TMR0_FUNC_BIT = 2;
  localparam int          TMR0_GATE_BIT = 3;
  localparam int          TMR1_MODE_LSB = 4;
  localparam int          TMR1_FUNC_BIT = 6;
  localparam int          TMR1_GATE_BIT = 7;

  localparam logic [1:0]  MODE_13BIT    = 2'h0;
  localparam logic [1:0]  MODE_16BIT    = 2'h1;
  localparam logic [1:0]  MODE_RELOAD8  = 2'h2;
  localparam logic [1:0]  MODE_SPLIT    = 2'h3;

  // ==========================================================
  // Byte write strobes, flag clears, pin order
  localparam int          WR_LOW0       = 0;
  localparam int          WR_HIGH0      = 1;
  localparam int          WR_LOW1       = 2;
  localparam int          WR_HIGH1      = 3;
  localparam int          WR_LOW2       = 4;
  localparam int          WR_HIGH2      = 5;
  localparam int          WR_CAPLOW     = 6;
  localparam int          WR_CAPHIGH    = 7;
  localparam int          NUM_WR        = 8;

  localparam int          FL_OVF0       = 0;
  localparam int          FL_OVF1       = 1;
  localparam int          FL_OVF2       = 2;
  localparam int          FL_EXT2       = 3;
  localparam int          NUM_FL        = 4;

  localparam int          PIN_A         = 0;
  localparam int          PIN_B         = 1;
  localparam int          PIN_C         = 2;
  localparam int          PIN_TRIG      = 3;
  localparam int          NUM_PINS      = 4;

  // ==========================================================
  // Values
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [15:0] WORD_FULL     = 16'hFFFF;

endpackage

// File: hdl/ttc_prescale.sv
// Machine-cycle, divide-by-12 and divide-by-2 enable generator
`timescale 1ns/1ps
`default_nettype none
module ttc_prescale
  import ttc_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  ttc_tick_if.src     tk
);
  import ttc_pkg::*;

  typedef struct packed {
    logic [MC_CNT_W-1:0]  phase;
    logic [STD_CNT_W-1:0] mcs;
    logic                 mc;
    logic                 std;
    logic                 half;
  } ttc_pre_t;

  ttc_pre_t st;
  ttc_pre_t next_st;

  always_comb begin
    next_st      = st;
    next_st.mc   = (st.phase == MC_CNT_W'(MC_CLKS - 2));
    next_st.std  = 1'b0;
    next_st.half = ~st.half;
    next_st.phase = (st.phase == MC_CNT_W'(MC_CLKS - 1)) ? '0 : st.phase + 1'b1;
    if (next_st.mc) begin
      next_st.std = (st.mcs == STD_CNT_W'(STD_DIV_MC - 1));
      next_st.mcs = next_st.std ? '0 : st.mcs + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.mc   = st.mc;
  assign tk.std  = st.std;
  assign tk.half = st.half;
endmodule
`default_nettype wire

// File: hdl/ttc_tick_if.sv
// Rate enables shared between the prescaler, edge sampler and counters
`timescale 1ns/1ps
`default_nettype none
interface ttc_tick_if;
  logic mc;
  logic std;
  logic half;
  modport src (output mc, output std, output half);
  modport dst (input mc, input std, input half);
endinterface
`default_nettype wire

// File: hdl/ttc_top.sv
// Timer 0, timer 1 and timer 2 counting, reload, capture and clock-out
`timescale 1ns/1ps
`default_nettype none
module ttc_top
  import ttc_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic [7:0]               timer_mode_reg,
  input  wire logic                     timer0_turbo_sel,
  input  wire logic                     timer1_turbo_sel,
  input  wire logic                     third_turbo_sel,
  input  wire logic                     run_bit,
  input  wire logic                     second_run_bit,
  input  wire logic                     gate_input_pin0,
  input  wire logic                     gate_input_pin1,
  input  wire logic                     count_pin_a,
  input  wire logic                     count_pin_b,
  input  wire logic                     third_count_pin,
  input  wire logic                     trigger_pin,
  input  wire logic                     third_source_select,
  input  wire logic                     third_run_bit,
  input  wire logic                     tx_baud_select,
  input  wire logic                     rx_baud_select,
  input  wire logic                     capture_reload_select,
  input  wire logic                     clock_out_enable,
  input  wire logic                     external_enable,
  input  wire logic                     capture_clear_enable,
  input  wire logic                     down_count_enable,
  input  wire logic [ttc_pkg::NUM_WR-1:0] byte_wr,
  input  wire logic [7:0]               byte_wr_data,
  input  wire logic [ttc_pkg::NUM_FL-1:0] flag_clr,
  output var  logic [15:0]              timer0_count,
  output var  logic [15:0]              timer1_count,
  output var  logic [15:0]              timer2_count,
  output var  logic [15:0]              capture_value,
  output var  logic                     overflow_flag,
  output var  logic                     second_overflow_flag,
  output var  logic                     third_overflow_flag,
  output var  logic                     external_flag,
  output var  logic                     third_irq,
  output var  logic                     timer1_baud_tick,
  output var  logic                     timer2_baud_tick,
  output var  logic                     clock_out_pin
);
  import ttc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]  low0;
    logic [7:0]  high0;
    logic [7:0]  low1;
    logic [7:0]  high1;
    logic [15:0] cnt2;
    logic [15:0] cap2;
    logic        ovf0;
    logic        ovf1;
    logic        ovf2;
    logic        ext2;
    logic        irq2;
    logic        baud1;
    logic        baud2;
    logic        clkout;
  } ttc_state_t;

  ttc_state_t st;
  ttc_state_t next_st;

  ttc_tick_if tk ();
  logic [NUM_PINS-1:0] fall;

  ttc_prescale u_pre (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tk      (tk)
  );

  ttc_edge #(.N(NUM_PINS)) u_edge (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tk      (tk),
    .pins    ({trigger_pin, third_count_pin, count_pin_b, count_pin_a}),
    .fall    (fall)
  );

  // ==========================================================
  // One counting step of timer 0 or 1: {overflow, high, low}
  function automatic logic [16:0] f_step(input logic [1:0] m, input logic [7:0] h, input logic [7:0] l);
    logic [5:0]  lo5;
    logic [8:0]  hi9;
    logic [8:0]  l9;
    logic [16:0] s;
    lo5 = {1'b0, l[4:0]} + 6'h01;
    hi9 = {1'b0, h} + 9'h001;
    l9  = {1'b0, l} + 9'h001;
    s   = {1'b0, h, l} + 17'h00001;
    unique case (m)
      MODE_13BIT:   f_step = lo5[5] ? {hi9, l[7:5], lo5[4:0]} : {1'b0, h, l[7:5], lo5[4:0]};
      MODE_16BIT:   f_step = s;
      MODE_RELOAD8: f_step = l9[8] ? {1'b1, h, h} : {1'b0, h, l9[7:0]};
      MODE_SPLIT:   f_step = {1'b0, h, l};
    endcase
  endfunction

  // ==========================================================
  // Decode
  logic [1:0]  mode0;
  logic [1:0]  mode1;
  logic        split0;
  logic        tick0;
  logic        tick1;
  logic        cyc0;
  logic        step0;
  logic        step1;
  logic        step0h;
  logic        baud_md;
  logic        co_md;
  logic        cap_md;
  logic        ud_md;
  logic        tick2;
  logic        step2;
  logic        trig;
  logic        no_wr;
  logic [16:0] r0;
  logic [16:0] r1;
  logic [16:0] inc2;

  always_comb begin
    mode0  = timer_mode_reg[TMR0_MODE_LSB +: 2];
    mode1  = timer_mode_reg[TMR1_MODE_LSB +: 2];
    split0 = (mode0 == MODE_SPLIT);
    cyc0   = timer0_turbo_sel ? tk.mc : tk.std;
    tick0  = timer_mode_reg[TMR0_FUNC_BIT] ? fall[PIN_A] : cyc0;
    tick1  = timer_mode_reg[TMR1_FUNC_BIT] ? fall[PIN_B] : (timer1_turbo_sel ? tk.mc : tk.std);
    step0  = tick0 & run_bit & (~timer_mode_reg[TMR0_GATE_BIT] | gate_input_pin0);
    // Timer 1 runs free of its run bit while timer 0 borrows it
    step1  = tick1 & (split0 | second_run_bit) & (~timer_mode_reg[TMR1_GATE_BIT] | gate_input_pin1);
    step0h = split0 & second_run_bit & cyc0;
    r0     = f_step(mode0, st.high0, st.low0);
    r1     = f_step(mode1, st.high1, st.low1);
    baud_md = (tx_baud_select | rx_baud_select) & ~clock_out_enable;
    co_md   = clock_out_enable & ~capture_reload_select;
    cap_md  = capture_reload_select & ~(tx_baud_select | rx_baud_select);
    ud_md   = ~capture_reload_select & ~(tx_baud_select | rx_baud_select) & ~clock_out_enable & down_count_enable;
    // Clock-out counts at clock/2 so one wrap is half a period
    tick2  = third_source_select ? fall[PIN_C]
           : (co_md ? tk.half : (third_turbo_sel ? tk.mc : tk.std));
    step2  = third_run_bit & tick2;
    trig   = fall[PIN_TRIG] & external_enable;
    inc2   = {1'b0, st.cnt2} + 17'h00001;
    no_wr  = (byte_wr == '0);
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic set0;
    logic set1;
    logic set2;
    logic setx;
    logic tglx;
    logic [8:0] lo9;
    logic [8:0] hi9;
    set0 = 1'b0;
    set1 = 1'b0;
    set2 = 1'b0;
    setx = 1'b0;
    tglx = 1'b0;
    lo9  = {1'b0, st.low0} + 9'h001;
    hi9  = {1'b0, st.high0} + 9'h001;
    next_st       = st;
    next_st.baud1 = 1'b0;
    next_st.baud2 = 1'b0;

    if (split0) begin
      if (step0) begin
        next_st.low0 = lo9[7:0];
        set0 = lo9[8];
      end
      if (step0h) begin
        next_st.high0 = hi9[7:0];
        set1 = hi9[8];
      end
    end else if (step0) begin
      {set0, next_st.high0, next_st.low0} = r0;
    end

    if (mode1 != MODE_SPLIT && step1) begin
      {next_st.baud1, next_st.high1, next_st.low1} = r1;
      set1 = set1 | (r1[16] & ~split0);
    end

    if (cap_md) begin
      if (step2) begin
        next_st.cnt2 = inc2[15:0];
        set2 = inc2[16];
      end
      if (trig) begin
        next_st.cap2 = st.cnt2;
        setx = 1'b1;
        if (capture_clear_enable) begin
          next_st.cnt2 = WORD_RESET;
        end
      end
    end else if (ud_md) begin
      if (step2 && trigger_pin) begin
        next_st.cnt2 = inc2[16] ? st.cap2 : inc2[15:0];
        set2 = inc2[16];
        tglx = inc2[16];
      end else if (step2) begin
        next_st.cnt2 = (st.cnt2 == st.cap2) ? WORD_FULL : st.cnt2 - 16'h0001;
        set2 = (st.cnt2 == st.cap2);
        tglx = (st.cnt2 == st.cap2);
      end
    end else if (baud_md || co_md) begin
      if (step2 && inc2[16]) begin
        next_st.cnt2   = st.cap2;
        next_st.baud2  = baud_md;
        next_st.clkout = co_md ? ~st.clkout : st.clkout;
      end else if (step2) begin
        next_st.cnt2 = inc2[15:0];
      end
      setx = baud_md & trig;
    end else begin
      if (step2) begin
        next_st.cnt2 = inc2[16] ? st.cap2 : inc2[15:0];
        set2 = inc2[16];
      end
      if (trig) begin
        next_st.cnt2 = st.cap2;
        setx = 1'b1;
      end
    end

    // Hardware set wins over a clear in the same cycle
    next_st.ovf0 = (st.ovf0 & ~flag_clr[FL_OVF0]) | set0;
    next_st.ovf1 = (st.ovf1 & ~flag_clr[FL_OVF1]) | set1;
    next_st.ovf2 = (st.ovf2 & ~flag_clr[FL_OVF2]) | set2;
    next_st.ext2 = tglx ? ~st.ext2 : ((st.ext2 & ~flag_clr[FL_EXT2]) | setx);

    // Software byte writes override counting
    if (byte_wr[WR_LOW0])    next_st.low0       = byte_wr_data;
    if (byte_wr[WR_HIGH0])   next_st.high0      = byte_wr_data;
    if (byte_wr[WR_LOW1])    next_st.low1       = byte_wr_data;
    if (byte_wr[WR_HIGH1])   next_st.high1      = byte_wr_data;
    if (byte_wr[WR_LOW2])    next_st.cnt2[7:0]  = byte_wr_data;
    if (byte_wr[WR_HIGH2])   next_st.cnt2[15:8] = byte_wr_data;
    if (byte_wr[WR_CAPLOW])  next_st.cap2[7:0]  = byte_wr_data;
    if (byte_wr[WR_CAPHIGH]) next_st.cap2[15:8] = byte_wr_data;

    next_st.irq2 = next_st.ovf2 | (next_st.ext2 & ~ud_md);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timer0_count         = {st.high0, st.low0};
  assign timer1_count         = {st.high1, st.low1};
  assign timer2_count         = st.cnt2;
  assign capture_value        = st.cap2;
  assign overflow_flag        = st.ovf0;
  assign second_overflow_flag = st.ovf1;
  assign third_overflow_flag  = st.ovf2;
  assign external_flag        = st.ext2;
  assign third_irq            = st.irq2;
  assign timer1_baud_tick     = st.baud1;
  assign timer2_baud_tick     = st.baud2;
  assign clock_out_pin        = st.clkout;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_tmr0_gate_hold:
    assert property (!split0 && !step0 && no_wr |=> $stable(timer0_count))
    else $error("timer 0 moved without an accepted count");
  a_tmr0_m0_wrap:
    assert property (mode0 == MODE_13BIT && step0 && no_wr && st.high0 == 8'hFF && st.low0[4:0] == 5'h1F
                     |=> st.high0 == 8'h00 && st.low0[4:0] == 5'h00 && st.ovf0)
    else $error("13-bit wrap did not clear count and set flag");
  a_tmr0_m1_wrap:
    assert property (mode0 == MODE_16BIT && step0 && no_wr && timer0_count == WORD_FULL
                     |=> timer0_count == WORD_RESET && st.ovf0)
    else $error("16-bit wrap did not set flag");
  a_tmr0_reload:
    assert property (mode0 == MODE_RELOAD8 && step0 && no_wr && st.low0 == 8'hFF
                     |=> st.low0 == $past(st.high0) && $stable(st.high0) && st.ovf0)
    else $error("8-bit reload failed");
  a_tmr1_freeze:
    assert property (mode1 == MODE_SPLIT && no_wr |=> $stable(timer1_count))
    else $error("timer 1 moved in mode 3");
  a_t2_cap_wrap:
    assert property (cap_md && step2 && !trig && no_wr && st.cnt2 == WORD_FULL
                     |=> st.cnt2 == WORD_RESET && st.ovf2 && st.irq2)
    else $error("capture-mode wrap did not flag");
  a_t2_capture:
    assert property (cap_md && trig && no_wr |=> st.cap2 == $past(st.cnt2) && st.ext2)
    else $error("capture did not copy count");
  a_t2_down_load:
    assert property (ud_md && step2 && !trigger_pin && no_wr && st.cnt2 == st.cap2
                     |=> st.cnt2 == WORD_FULL && st.ext2 != $past(st.ext2))
    else $error("down count past capture value did not load FFFF");
  a_t2_clk_toggle:
    assert property (co_md && step2 && no_wr && st.cnt2 == WORD_FULL
                     |=> clock_out_pin != $past(clock_out_pin) && st.cnt2 == $past(st.cap2))
    else $error("clock-out did not toggle on wrap");
endmodule
`default_nettype wire

// File: verif/three_timer_counter_unit_test.sv
// Self-checking bench for the three-timer counter unit
`timescale 1ns/1ps
`default_nettype none
module three_timer_counter_unit_test;
  import ttc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  mode    = 8'h00;
  logic [2:0]  turbo   = 3'h0;
  logic [1:0]  run     = 2'h0;
  // Timer 2: src,run,tx,rx,cap_rl,clk_out,ext_en,cap_clr,down
  logic [8:0]  t2c     = 9'h000;
  logic [7:0]  wr      = 8'h00;
  logic [7:0]  wdat    = 8'h00;
  logic [3:0]  clr     = 4'h0;
  logic [5:0]  pins;
  logic [15:0] timer0_count, timer1_count, timer2_count, capture_value;
  logic        overflow_flag, second_overflow_flag, third_overflow_flag, external_flag;
  logic        third_irq, timer1_baud_tick, timer2_baud_tick, clock_out_pin;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  ttc_pin_model pm (.clk_sys, .pins);

  ttc_top uut (
    .clk_sys, .resetn, .timer_mode_reg(mode),
    .timer0_turbo_sel(turbo[0]), .timer1_turbo_sel(turbo[1]), .third_turbo_sel(turbo[2]),
    .run_bit(run[0]), .second_run_bit(run[1]),
    .gate_input_pin0(pins[4]), .gate_input_pin1(pins[5]),
    .count_pin_a(pins[0]), .count_pin_b(pins[1]), .third_count_pin(pins[2]), .trigger_pin(pins[3]),
    .third_source_select(t2c[0]), .third_run_bit(t2c[1]), .tx_baud_select(t2c[2]),
    .rx_baud_select(t2c[3]), .capture_reload_select(t2c[4]), .clock_out_enable(t2c[5]),
    .external_enable(t2c[6]), .capture_clear_enable(t2c[7]), .down_count_enable(t2c[8]),
    .byte_wr(wr), .byte_wr_data(wdat), .flag_clr(clr),
    .timer0_count, .timer1_count, .timer2_count, .capture_value,
    .overflow_flag, .second_overflow_flag, .third_overflow_flag, .external_flag,
    .third_irq, .timer1_baud_tick, .timer2_baud_tick, .clock_out_pin
  );

  // ==========================================================
  // Infrastructure
  initial forever #2 clk_sys = ~clk_sys;

  task automatic wrap_up;
    $display("Comparisons: %0d, mismatches: %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Guards against a hang; the whole run needs a few thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic cfg(input logic [7:0] m, input logic [2:0] tb, input logic [1:0] r, input logic [8:0] t);
    @(posedge clk_sys);
    mode  <= m;
    turbo <= tb;
    run   <= r;
    t2c   <= t;
  endtask

  task automatic put(input int idx, input logic [7:0] d);
    @(posedge clk_sys);
    wr[idx] <= 1'b1;
    wdat    <= d;
    @(posedge clk_sys);
    wr[idx] <= 1'b0;
  endtask

  task automatic flags_off;
    @(posedge clk_sys);
    clr <= 4'hF;
    @(posedge clk_sys);
    clr <= 4'h0;
  endtask

  function automatic logic [15:0] pick(input int s);
    case (s)
      0: return timer0_count;
      1: return timer1_count;
      2: return timer2_count;
      3: return {15'h0000, overflow_flag};
      4: return {15'h0000, second_overflow_flag};
      5: return {15'h0000, third_overflow_flag};
      6: return {15'h0000, timer2_baud_tick};
      8: return {15'h0000, timer1_baud_tick};
      default: return {15'h0000, clock_out_pin};
    endcase
  endfunction

  task automatic wait_for(input int s, input logic [15:0] v);
    int k = 0;
    #1;
    while (pick(s) !== v && k < 2000) begin
      cyc(1);
      k++;
    end
    check(pick(s), v, "wait");
  endtask

  // 120 clocks always hold exactly 120/period ticks, whatever the phase
  task automatic span(input int s, input logic [15:0] exp);
    logic [15:0] a;
    cyc(4);
    a = pick(s);
    cyc(120);
    check(pick(s) - a, exp, "count rate");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_rate;
    cfg(8'h01, 3'h0, 2'h1, 9'h000);
    span(0, 16'h000A);
    cfg(8'h01, 3'h1, 2'h1, 9'h000);
    span(0, 16'h001E);
    cfg(8'h09, 3'h1, 2'h1, 9'h000);
    pm.level(4, 1'b0);
    span(0, 16'h0000);
    pm.level(4, 1'b1);
    span(0, 16'h001E);
    cfg(8'h01, 3'h1, 2'h0, 9'h000);
    span(0, 16'h0000);
  endtask

  task automatic t_pins;
    logic [15:0] a;
    logic [15:0] b;
    cfg(8'h55, 3'h0, 2'h3, 9'h000);
    cyc(4);
    a = timer0_count;
    b = timer1_count;
    pm.falls(0, 5, 8);
    pm.falls(1, 3, 20);
    cyc(4);
    check(timer0_count - a, 16'h0005, "pin a edges");
    check(timer1_count - b, 16'h0003, "pin b edges");
  endtask

  task automatic wrap0(input logic [7:0] m, hi, lo, input logic [15:0] mask, exp);
    cfg(m, 3'h1, 2'h0, 9'h000);
    put(WR_HIGH0, hi);
    put(WR_LOW0, lo);
    flags_off;
    cfg(m, 3'h1, 2'h1, 9'h000);
    wait_for(3, 16'h0001);
    check(timer0_count & mask, exp, "timer 0 wrap");
  endtask

  task automatic t_split;
    logic [15:0] a;
    cfg(8'h10, 3'h3, 2'h2, 9'h000);
    cfg(8'h30, 3'h3, 2'h2, 9'h000);
    span(1, 16'h0000);
    put(WR_HIGH0, 8'hFF);
    put(WR_LOW0, 8'h10);
    flags_off;
    cfg(8'h03, 3'h3, 2'h2, 9'h000);
    wait_for(4, 16'h0001);
    check(timer0_count, 16'h0010, "split high wrap");
    check(overflow_flag, 1'b0, "timer 0 flag idle");
    cfg(8'h13, 3'h3, 2'h1, 9'h000);
    span(0, 16'h001E);
    span(1, 16'h001E);
  endtask

  task automatic t_baud1;
    cfg(8'h20, 3'h2, 2'h0, 9'h000);
    put(WR_HIGH1, 8'hF0);
    put(WR_LOW1, 8'hFE);
    flags_off;
    cfg(8'h20, 3'h2, 2'h2, 9'h000);
    wait_for(8, 16'h0001);
    check(timer1_count, 16'hF0F0, "timer 1 reload");
    check(second_overflow_flag, 1'b1, "timer 1 flag");
    cyc(1);
    check(timer1_baud_tick, 1'b0, "baud tick one cycle");
  endtask

  task automatic t2_base;
    logic [15:0] a;
    cfg(8'h00, 3'h0, 2'h0, 9'h002);
    span(2, 16'h000A);
    cfg(8'h00, 3'h4, 2'h0, 9'h002);
    span(2, 16'h001E);
    cfg(8'h00, 3'h4, 2'h0, 9'h003);
    cyc(4);
    a = timer2_count;
    pm.falls(2, 4, 8);
    cyc(4);
    check(timer2_count - a, 16'h0004, "pin c edges");
  endtask

  task automatic t2_capture;
    cfg(8'h00, 3'h4, 2'h0, 9'h0D0);
    put(WR_HIGH2, 8'h12);
    put(WR_LOW2, 8'h34);
    flags_off;
    pm.falls(3, 1, 8);
    cyc(4);
    check(capture_value, 16'h1234, "capture");
    check(external_flag, 1'b1, "capture flag");
    check(third_irq, 1'b1, "capture irq");
    check(timer2_count, 16'h0000, "capture clear");
    put(WR_HIGH2, 8'hFF);
    put(WR_LOW2, 8'hFE);
    cfg(8'h00, 3'h4, 2'h0, 9'h0D2);
    wait_for(5, 16'h0001);
    check(timer2_count, 16'h0000, "capture wrap");
  endtask

  task automatic t2_reload;
    cfg(8'h00, 3'h4, 2'h0, 9'h040);
    put(WR_CAPHIGH, 8'h80);
    put(WR_CAPLOW, 8'h00);
    put(WR_HIGH2, 8'hFF);
    put(WR_LOW2, 8'hFF);
    flags_off;
    cfg(8'h00, 3'h4, 2'h0, 9'h042);
    wait_for(5, 16'h0001);
    check(timer2_count, 16'h8000, "up reload");
    cfg(8'h00, 3'h4, 2'h0, 9'h040);
    put(WR_LOW2, 8'h55);
    flags_off;
    pm.falls(3, 1, 8);
    cyc(4);
    check(timer2_count, 16'h8000, "pin reload");
    check(external_flag, 1'b1, "pin reload flag");
  endtask

  task automatic t2_updown;
    cfg(8'h00, 3'h4, 2'h0, 9'h100);
    put(WR_CAPHIGH, 8'h00);
    put(WR_CAPLOW, 8'h10);
    put(WR_HIGH2, 8'h00);
    put(WR_LOW2, 8'h11);
    pm.level(3, 1'b0);
    flags_off;
    cfg(8'h00, 3'h4, 2'h0, 9'h102);
    wait_for(2, 16'hFFFF);
    check(third_overflow_flag, 1'b1, "down reload flag");
    check(external_flag, 1'b1, "down toggle");
    // Stop counting so the up reload cannot raise the overflow again
    cfg(8'h00, 3'h4, 2'h0, 9'h100);
    pm.level(3, 1'b1);
    @(posedge clk_sys);
    clr <= 4'h4;
    @(posedge clk_sys);
    clr <= 4'h0;
    cyc(2);
    check(external_flag, 1'b1, "ext flag held");
    check(third_irq, 1'b0, "no ext irq");
    cfg(8'h00, 3'h4, 2'h0, 9'h102);
    wait_for(2, 16'h0010);
    check(external_flag, 1'b0, "up toggle");
    check(third_overflow_flag, 1'b1, "up reload flag");
  endtask

  task automatic t2_baud;
    cfg(8'h00, 3'h4, 2'h0, 9'h044);
    put(WR_CAPHIGH, 8'hFF);
    put(WR_CAPLOW, 8'hF0);
    put(WR_HIGH2, 8'hFF);
    put(WR_LOW2, 8'hFE);
    flags_off;
    cfg(8'h00, 3'h4, 2'h0, 9'h046);
    wait_for(6, 16'h0001);
    cyc(1);
    check(third_overflow_flag, 1'b0, "baud no flag");
    check(timer2_count & 16'hFFF0, 16'hFFF0, "baud reload");
    // Receive select alone, stopped: a trigger edge must not reload
    cfg(8'h00, 3'h4, 2'h0, 9'h048);
    put(WR_LOW2, 8'hF5);
    pm.falls(3, 1, 8);
    cyc(4);
    check(external_flag, 1'b1, "baud pin flag");
    check(third_irq, 1'b1, "baud pin irq");
    check(timer2_count, 16'hFFF5, "baud pin no reload");
  endtask

  task automatic t2_clkout;
    logic [15:0] n;
    cfg(8'h00, 3'h4, 2'h0, 9'h020);
    flags_off;
    cfg(8'h00, 3'h4, 2'h0, 9'h022);
    wait_for(7, 16'h0001);
    wait_for(7, 16'h0000);
    for (int v = 0; v < 2; v++) begin
      n = 16'h0000;
      while (clock_out_pin === v[0] && n < 16'h03E8) begin
        cyc(1);
        n++;
      end
      check(n, 16'h0020, "clock-out half period");
    end
    check(third_overflow_flag, 1'b0, "clock-out no flag");
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(4);
    t_rate();
    t_pins();
    wrap0(8'h00, 8'hFF, 8'h1F, 16'hFF1F, 16'h0000);
    wrap0(8'h01, 8'hFF, 8'hFF, 16'hFFFF, 16'h0000);
    wrap0(8'h02, 8'hA5, 8'hFE, 16'hFFFF, 16'hA5A5);
    t_split();
    t_baud1();
    t2_base();
    t2_capture();
    t2_reload();
    t2_updown();
    t2_baud();
    t2_clkout();
    wrap_up();
  end
endmodule
`default_nettype wire

// File: verif/ttc_pin_model.sv
// Far-side pin model: count, trigger and gate pins of the timer unit
`timescale 1ns/1ps
`default_nettype none
module ttc_pin_model (
  input  wire logic       clk_sys,
  output var  logic [5:0] pins
);
  // ==========================================================
  // Order: pin a, pin b, third count, trigger, gate 0, gate 1
  initial pins = 6'h3F;

  task automatic level(input int i, input logic v);
    @(posedge clk_sys);
    pins[i] <= v;
  endtask

  // Each level stands at least two machine cycles so no sample misses it
  task automatic falls(input int i, input int n, input int hold);
    repeat (n) begin
      level(i, 1'b0);
      repeat (hold) @(posedge clk_sys);
      level(i, 1'b1);
      repeat (hold) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire
